// ===== common/pif_pkg.sv
// constants shared by the peripheral interrupt flag bank
package pif_pkg;

  // register bus geometry
  localparam int unsigned PIF_ADDR_W = 4;
  localparam int unsigned PIF_DATA_W = 8;

  // register offsets
  localparam logic [PIF_ADDR_W-1:0] PIF_OFS_FLAGS_ONE   = 4'h0;
  localparam logic [PIF_ADDR_W-1:0] PIF_OFS_FLAGS_TWO   = 4'h1;
  localparam logic [PIF_ADDR_W-1:0] PIF_OFS_FLAGS_THREE = 4'h2;
  localparam logic [PIF_ADDR_W-1:0] PIF_OFS_IRQ_STATUS  = 4'h3;
  localparam logic [PIF_ADDR_W-1:0] PIF_OFS_IRQ_MASK    = 4'h4;

  // field positions in peripheral_flags_one
  localparam int unsigned PIF_ONE_CONV_DONE = 6;
  localparam int unsigned PIF_ONE_SERIAL_RX = 5;
  localparam int unsigned PIF_ONE_SERIAL_TX = 4;
  localparam int unsigned PIF_ONE_SYNC_SER  = 3;
  localparam int unsigned PIF_ONE_CAPCOMP   = 2;
  localparam int unsigned PIF_ONE_PERIOD    = 1;
  localparam int unsigned PIF_ONE_T1_OVF    = 0;

  // field positions in peripheral_flags_two
  localparam int unsigned PIF_TWO_OSC_FAIL  = 7;
  localparam int unsigned PIF_TWO_COMPARE   = 6;
  localparam int unsigned PIF_TWO_BUS_COLL  = 3;
  localparam int unsigned PIF_TWO_VOLT_DET  = 2;
  localparam int unsigned PIF_TWO_T3_OVF    = 1;
  localparam int unsigned PIF_TWO_CAPCOMP   = 0;

  // implemented and software-writable bits
  localparam logic [PIF_DATA_W-1:0] PIF_ONE_IMPL     = 8'h7F;
  localparam logic [PIF_DATA_W-1:0] PIF_ONE_WRITABLE = 8'h4F;
  localparam logic [PIF_DATA_W-1:0] PIF_TWO_IMPL     = 8'hCF;
  localparam logic [PIF_DATA_W-1:0] PIF_IRQ_IMPL     = 8'h03;

  // interrupt status bits: one summary event for each of flag registers one and two
  localparam int unsigned PIF_IRQ_ONE = 0;
  localparam int unsigned PIF_IRQ_TWO = 1;

  // reset values
  localparam logic [PIF_DATA_W-1:0] PIF_RESET_FLAGS = 8'h00;
  localparam logic [PIF_DATA_W-1:0] PIF_RESET_MASK  = 8'h00;

  // capture/compare unit operating modes
  typedef enum logic [1:0] {
    PIF_CC_CAPTURE = 2'h0,
    PIF_CC_COMPARE = 2'h1,
    PIF_CC_PWM     = 2'h2,
    PIF_CC_OFF     = 2'h3
  } pif_cc_mode_type;

endpackage

// ===== design/pif_sticky_bank.sv
// bank of sticky flag bits where a set in the same cycle beats a clear
`timescale 1ns/100ps
module pif_sticky_bank #(
  parameter int unsigned           WIDTH = 8,
  parameter logic [WIDTH-1:0]      INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);

  // refuse a bank that holds no bits
  if (WIDTH < 1) begin : g_bad_width
    $error("pif_sticky_bank needs at least one bit");
  end

  // set wins so an event in the clearing cycle is never lost
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= INIT;
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule

// ===== design/pif_flags.sv
// peripheral interrupt request flag bank with register port and summary interrupt
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module pif_flags
  import pif_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic [PIF_ADDR_W-1:0] ADDR,
  input  wire logic [PIF_DATA_W-1:0] WR_DATA,
  input  wire logic                  WR_EN,
  input  wire logic                  RD_EN,
  output logic      [PIF_DATA_W-1:0] RD_DATA,
  input  wire logic                  CONV_DONE,
  input  wire logic                  RX_BUF_FULL,
  input  wire logic                  TX_BUF_EMPTY,
  input  wire logic                  SYNC_SER_DONE,
  input  wire logic                  CC_ONE_EVENT,
  input  wire logic [1:0]            CC_ONE_MODE,
  input  wire logic                  PERIOD_MATCH,
  input  wire logic                  TIMER_ONE_OVF,
  input  wire logic                  OSC_SWITCHED,
  input  wire logic                  COMPARATOR_CHANGE,
  input  wire logic                  BUS_COLLISION,
  input  wire logic                  VOLTAGE_LOW,
  input  wire logic                  TIMER_THREE_OVF,
  input  wire logic                  CC_TWO_EVENT,
  input  wire logic [1:0]            CC_TWO_MODE,
  output logic      [PIF_DATA_W-1:0] FLAGS_ONE,
  output logic      [PIF_DATA_W-1:0] FLAGS_TWO,
  output logic                       IRQ
);
  import pif_pkg::*;

  // refuse package constants that the fixed eight-bit layout cannot serve
  if (PIF_DATA_W != 8) begin : g_bad_data_w
    $error("pif_flags needs eight-bit flag registers");
  end

  // five registers need at least three address bits
  if (PIF_ADDR_W < 3) begin : g_bad_addr_w
    $error("pif_flags address too narrow for its register map");
  end

  // every field position must fall inside a register
  if (PIF_ONE_CONV_DONE >= PIF_DATA_W || PIF_TWO_OSC_FAIL >= PIF_DATA_W) begin : g_bad_field
    $error("pif_flags field position outside the register");
  end

  // the serial bits follow buffer state, so software must never write them
  if (PIF_ONE_WRITABLE[PIF_ONE_SERIAL_RX]
      || PIF_ONE_WRITABLE[PIF_ONE_SERIAL_TX]) begin : g_bad_ro
    $error("pif_flags serial bits marked writable");
  end

  // a writable bit that is not implemented would read back wrong
  if ((PIF_ONE_WRITABLE & ~PIF_ONE_IMPL) != 8'h00) begin : g_bad_wr_mask
    $error("pif_flags writable bit outside the implemented set");
  end

  // offsets must differ or the read mux would hide a register
  if (PIF_OFS_FLAGS_ONE == PIF_OFS_FLAGS_TWO
      || PIF_OFS_FLAGS_TWO == PIF_OFS_FLAGS_THREE
      || PIF_OFS_FLAGS_THREE == PIF_OFS_IRQ_STATUS
      || PIF_OFS_IRQ_STATUS == PIF_OFS_IRQ_MASK) begin : g_bad_offsets
    $error("pif_flags register offsets overlap");
  end

  // both summary bits must exist in status and mask
  if (!PIF_IRQ_IMPL[PIF_IRQ_ONE] || !PIF_IRQ_IMPL[PIF_IRQ_TWO]) begin : g_bad_irq
    $error("pif_flags summary bit not implemented");
  end

  // flags must start clear after reset
  if (PIF_RESET_FLAGS != 8'h00) begin : g_bad_reset
    $error("pif_flags reset value must clear every flag");
  end

  // strobe qualified by an address match, shared by every write decode
  function automatic logic reg_hit(
    input logic                  strobe,
    input logic [PIF_ADDR_W-1:0] addr,
    input logic [PIF_ADDR_W-1:0] ofs
  );
    return strobe && (addr == ofs);
  endfunction

  // any hardware set of a flag that is clear raises its summary event
  function automatic logic rise_any(
    input logic [PIF_DATA_W-1:0] set,
    input logic [PIF_DATA_W-1:0] held
  );
    return |(set & ~held);
  endfunction

  // a capture/compare event only counts in capture or compare mode
  function automatic logic cc_event_live(input logic ev, input logic [1:0] mode);
    logic live;
    live = 1'b0;
    case (pif_cc_mode_type'(mode))
      PIF_CC_CAPTURE: live = ev;
      PIF_CC_COMPARE: live = ev;
      PIF_CC_PWM:     live = 1'b0;
      default:        live = 1'b0;
    endcase
    return live;
  endfunction

  // clear vector for a software write: writable bits written as zero
  function automatic logic [PIF_DATA_W-1:0] sw_clear(
    input logic                  hit,
    input logic [PIF_DATA_W-1:0] data,
    input logic [PIF_DATA_W-1:0] writable
  );
    return hit ? (writable & ~data) : '0;
  endfunction

  // set vector for a software write: writable bits written as one
  function automatic logic [PIF_DATA_W-1:0] sw_set(
    input logic                  hit,
    input logic [PIF_DATA_W-1:0] data,
    input logic [PIF_DATA_W-1:0] writable
  );
    return hit ? (writable & data) : '0;
  endfunction

  logic                  wr_one;
  logic                  wr_two;
  logic                  wr_status;
  logic                  wr_mask;
  logic [PIF_DATA_W-1:0] hw_set_one;
  logic [PIF_DATA_W-1:0] hw_set_two;
  logic [PIF_DATA_W-1:0] set_one;
  logic [PIF_DATA_W-1:0] clr_one;
  logic [PIF_DATA_W-1:0] set_two;
  logic [PIF_DATA_W-1:0] clr_two;
  logic [PIF_DATA_W-1:0] sticky_one;
  logic [PIF_DATA_W-1:0] sticky_two;
  logic                  serial_rx;
  logic                  serial_tx;
  logic                  serial_tx_prev;
  logic [PIF_DATA_W-1:0] irq_set;
  logic [PIF_DATA_W-1:0] irq_clr;
  logic [PIF_DATA_W-1:0] irq_status;
  logic [PIF_DATA_W-1:0] irq_mask;
  logic [PIF_DATA_W-1:0] view_one;
  logic [PIF_DATA_W-1:0] view_two;
  logic [PIF_DATA_W-1:0] next_rd_data;

  // write decode; unmapped writes fall through and change nothing
  assign wr_one    = reg_hit(WR_EN, ADDR, PIF_OFS_FLAGS_ONE);
  assign wr_two    = reg_hit(WR_EN, ADDR, PIF_OFS_FLAGS_TWO);
  assign wr_status = reg_hit(WR_EN, ADDR, PIF_OFS_IRQ_STATUS);
  assign wr_mask   = reg_hit(WR_EN, ADDR, PIF_OFS_IRQ_MASK);

  // hardware events of the first register; no enable term gates them
  always_comb begin
    hw_set_one                    = '0;
    hw_set_one[PIF_ONE_CONV_DONE] = CONV_DONE;
    hw_set_one[PIF_ONE_SYNC_SER]  = SYNC_SER_DONE;
    hw_set_one[PIF_ONE_CAPCOMP]   = cc_event_live(CC_ONE_EVENT,
                                                  CC_ONE_MODE);
    hw_set_one[PIF_ONE_PERIOD]    = PERIOD_MATCH;
    hw_set_one[PIF_ONE_T1_OVF]    = TIMER_ONE_OVF;
  end

  // hardware events of the second register
  always_comb begin
    hw_set_two                    = '0;
    hw_set_two[PIF_TWO_OSC_FAIL]  = OSC_SWITCHED;
    hw_set_two[PIF_TWO_COMPARE]   = COMPARATOR_CHANGE;
    hw_set_two[PIF_TWO_BUS_COLL]  = BUS_COLLISION;
    hw_set_two[PIF_TWO_VOLT_DET]  = VOLTAGE_LOW;
    hw_set_two[PIF_TWO_T3_OVF]    = TIMER_THREE_OVF;
    hw_set_two[PIF_TWO_CAPCOMP]   = cc_event_live(CC_TWO_EVENT, CC_TWO_MODE);
  end

  // software may set or clear writable bits; hardware set still wins
  assign set_one = hw_set_one | sw_set(wr_one, WR_DATA, PIF_ONE_WRITABLE);
  assign clr_one = sw_clear(wr_one, WR_DATA, PIF_ONE_WRITABLE);
  assign set_two = hw_set_two | sw_set(wr_two, WR_DATA, PIF_TWO_IMPL);
  assign clr_two = sw_clear(wr_two, WR_DATA, PIF_TWO_IMPL);

  // sticky part of the first flag register
  pif_sticky_bank #(
    .WIDTH (PIF_DATA_W),
    .INIT  (PIF_RESET_FLAGS)
  ) u_bank_one (
    .clk   (CLK),
    .reset (RESET),
    .set   (set_one & PIF_ONE_WRITABLE),
    .clr   (clr_one),
    .q     (sticky_one)
  );

  // sticky second flag register
  pif_sticky_bank #(
    .WIDTH (PIF_DATA_W),
    .INIT  (PIF_RESET_FLAGS)
  ) u_bank_two (
    .clk   (CLK),
    .reset (RESET),
    .set   (set_two & PIF_TWO_IMPL),
    .clr   (clr_two),
    .q     (sticky_two)
  );

  // receive flag mirrors the buffer level, so register writes cannot touch it
  always_ff @(posedge CLK) begin
    if (RESET) begin
      serial_rx <= 1'b0;
    end else begin
      serial_rx <= RX_BUF_FULL;
    end
  end

  // transmit flag mirrors the empty level and drops once the buffer is written
  always_ff @(posedge CLK) begin
    if (RESET) begin
      serial_tx <= 1'b0;
    end else begin
      serial_tx <= TX_BUF_EMPTY;
    end
  end

  // delayed copy of the transmit view, for spotting its rising edge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      serial_tx_prev <= 1'b0;
    end else begin
      serial_tx_prev <= serial_tx;
    end
  end

  // register views with unimplemented bits forced low
  always_comb begin
    view_one                    = sticky_one & PIF_ONE_IMPL;
    view_one[PIF_ONE_SERIAL_RX] = serial_rx;
    view_one[PIF_ONE_SERIAL_TX] = serial_tx;
    view_two                    = sticky_two & PIF_TWO_IMPL;
  end

  // summary events: any flag of a register set by hardware while it was clear
  always_comb begin
    irq_set              = '0;
    irq_set[PIF_IRQ_ONE] = rise_any(hw_set_one, sticky_one)
                         | (RX_BUF_FULL & ~serial_rx)
                         | (serial_tx & ~serial_tx_prev);
    irq_set[PIF_IRQ_TWO] = rise_any(hw_set_two, sticky_two);
    irq_clr              = wr_status ? (WR_DATA & PIF_IRQ_IMPL) : '0;
  end

  // write-one-to-clear interrupt status
  pif_sticky_bank #(
    .WIDTH (PIF_DATA_W),
    .INIT  (PIF_RESET_FLAGS)
  ) u_irq_status (
    .clk   (CLK),
    .reset (RESET),
    .set   (irq_set & PIF_IRQ_IMPL),
    .clr   (irq_clr),
    .q     (irq_status)
  );

  // interrupt mask, same layout as the status
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_mask <= PIF_RESET_MASK;
    end else if (wr_mask) begin
      irq_mask <= WR_DATA & PIF_IRQ_IMPL;
    end
  end

  // level interrupt, one cycle behind the status so the pin is a flop
  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // read mux; the third register holds no bits in this bank yet
  always_comb begin
    next_rd_data = '0;
    case (ADDR)
      PIF_OFS_FLAGS_ONE:   next_rd_data = view_one;
      PIF_OFS_FLAGS_TWO:   next_rd_data = view_two;
      PIF_OFS_FLAGS_THREE: next_rd_data = '0;
      PIF_OFS_IRQ_STATUS:  next_rd_data = irq_status;
      PIF_OFS_IRQ_MASK:    next_rd_data = irq_mask;
      default:             next_rd_data = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RD_DATA <= '0;
    end else if (RD_EN) begin
      RD_DATA <= next_rd_data;
    end else begin
      RD_DATA <= '0;
    end
  end

  // first flag copy for the enable and vectoring logic outside
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FLAGS_ONE <= PIF_RESET_FLAGS;
    end else begin
      FLAGS_ONE <= view_one;
    end
  end

  // second flag copy; a flop costs a cycle but keeps the pins glitch free
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FLAGS_TWO <= PIF_RESET_FLAGS;
    end else begin
      FLAGS_TWO <= view_two;
    end
  end

endmodule

// ===== dv/pif_flags_properties.sv
// concurrent checks on the flag bank ports
`timescale 1ns/100ps
module pif_flags_properties (
  input wire logic                          CLK,
  input wire logic                          RESET,
  input wire logic                          WR_EN,
  input wire logic                          CONV_DONE,
  input wire logic                          RX_BUF_FULL,
  input wire logic                          TX_BUF_EMPTY,
  input wire logic                          SYNC_SER_DONE,
  input wire logic                          CC_ONE_EVENT,
  input wire logic [1:0]                    CC_ONE_MODE,
  input wire logic                          PERIOD_MATCH,
  input wire logic                          TIMER_ONE_OVF,
  input wire logic                          OSC_SWITCHED,
  input wire logic [pif_pkg::PIF_DATA_W-1:0] FLAGS_ONE,
  input wire logic [pif_pkg::PIF_DATA_W-1:0] FLAGS_TWO
);
  import pif_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // an event taken at one edge shows on the copy two edges later
  property flag_sets(ev, fl);
    ev |-> ##2 fl;
  endproperty
  // pwm or off mode with no write: nothing may move the capture flag
  sequence cc_idle;
    CC_ONE_MODE[1] && !WR_EN ##2 1'b1;
  endsequence
  a_conv_sets: assert property (flag_sets(CONV_DONE, FLAGS_ONE[6]))
    else $error("converter flag not set");
  a_sync_sets: assert property (flag_sets(SYNC_SER_DONE, FLAGS_ONE[3]))
    else $error("sync serial flag not set");
  a_capcomp_sets: assert property (flag_sets(CC_ONE_EVENT && !CC_ONE_MODE[1], FLAGS_ONE[2]))
    else $error("capture flag not set");
  a_period_sets: assert property (flag_sets(PERIOD_MATCH, FLAGS_ONE[1]))
    else $error("period flag not set");
  a_overflow_sets: assert property (flag_sets(TIMER_ONE_OVF, FLAGS_ONE[0]))
    else $error("overflow flag not set");
  a_osc_sets: assert property (flag_sets(OSC_SWITCHED, FLAGS_TWO[7]))
    else $error("oscillator flag not set");
  a_unused_zero: assert property (!FLAGS_ONE[7] && FLAGS_TWO[5:4] == 2'h0)
    else $error("unused flag bit set");
  // the level is taken at one edge and shows on the copy two edges later
  a_rx_follows: assert property (FLAGS_ONE[5] == $past(RX_BUF_FULL, 2))
    else $error("receive flag off level");
  a_tx_follows: assert property (FLAGS_ONE[4] == $past(TX_BUF_EMPTY, 2))
    else $error("transmit flag off level");
  a_pwm_quiet: assert property (cc_idle |-> $stable(FLAGS_ONE[2]))
    else $error("capture flag moved in pwm");
  a_clear_by_write: assert property
    (|($past(FLAGS_ONE & PIF_ONE_WRITABLE) & ~FLAGS_ONE) |-> $past(WR_EN, 2))
    else $error("sticky flag fell without write");
endmodule
bind pif_flags pif_flags_properties pif_flags_properties_inst (.*);

// ===== dv/pif_periph_model.sv
// peripherals: turn bench requests into registered event lines
`timescale 1ns/100ps
module pif_periph_model (
  input  wire logic        clk,
  input  wire logic [12:0] req,
  output logic      [12:0] ev = 13'h0000
);
  // events leave a flop, as a same-clock peripheral drives them
  always @(posedge clk) begin
    ev <= req;
  end
endmodule

// ===== dv/pif_flags_tb.sv
// self-checking bench for the peripheral flag bank
`timescale 1ns/100ps
module pif_flags_tb;
  import pif_pkg::*;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_en = 1'h0;
  logic        rd_en = 1'h0;
  logic [1:0]  cc1_mode = 2'h0;
  logic [1:0]  cc2_mode = 2'h0;
  logic [12:0] req = 13'h0000;
  logic [12:0] ev;
  logic [7:0]  rd_data;
  logic [7:0]  flags_one;
  logic [7:0]  flags_two;
  logic        irq;
  int          failures = 0;
  int          checks_done = 0;
  always #5 clk = ~clk;
  // request bit i lands on flag one bit i; bits 12:7 feed flag two
  pif_periph_model pif_periph_model_inst (.clk(clk), .req(req), .ev(ev));
  pif_flags pif_flags_inst (.CLK(clk), .RESET(reset), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .CONV_DONE(ev[6]),
    .RX_BUF_FULL(ev[5]), .TX_BUF_EMPTY(ev[4]), .SYNC_SER_DONE(ev[3]),
    .CC_ONE_EVENT(ev[2]), .CC_ONE_MODE(cc1_mode), .PERIOD_MATCH(ev[1]),
    .TIMER_ONE_OVF(ev[0]), .OSC_SWITCHED(ev[12]), .COMPARATOR_CHANGE(ev[11]),
    .BUS_COLLISION(ev[10]), .VOLTAGE_LOW(ev[9]), .TIMER_THREE_OVF(ev[8]),
    .CC_TWO_EVENT(ev[7]), .CC_TWO_MODE(cc2_mode), .FLAGS_ONE(flags_one),
    .FLAGS_TWO(flags_two), .IRQ(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    chk(rd_data, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    req[i] <= 1'h1;
    @(posedge clk);
    req[i] <= 1'h0;
  endtask
  task automatic t_reset;
    for (int a = 0; a < 6; a++) rd(4'(a), 8'h00);
    rd(4'hF, 8'h00);
  endtask
  task automatic t_one;
    int bits[5] = '{0, 1, 2, 3, 6};
    foreach (bits[k]) begin
      pulse(bits[k]);
      rd(PIF_OFS_FLAGS_ONE, 8'h01 << bits[k]);
      chk(flags_one, 8'h01 << bits[k]);
      wr(PIF_OFS_FLAGS_ONE, 8'h00);
      rd(PIF_OFS_FLAGS_ONE, 8'h00);
    end
  endtask
  task automatic t_two;
    int pos[6] = '{0, 1, 2, 3, 6, 7};
    foreach (pos[k]) begin
      pulse(7 + k);
      rd(PIF_OFS_FLAGS_TWO, 8'h01 << pos[k]);
      chk(flags_two, 8'h01 << pos[k]);
      wr(PIF_OFS_FLAGS_TWO, 8'h00);
    end
    wr(PIF_OFS_FLAGS_TWO, 8'hFF);
    rd(PIF_OFS_FLAGS_TWO, PIF_TWO_IMPL);
    wr(PIF_OFS_FLAGS_TWO, 8'h00);
  endtask
  // read-only bits ignore writes and track the buffer levels
  task automatic t_serial;
    @(posedge clk);
    req[5] <= 1'h1;
    wr(PIF_OFS_FLAGS_ONE, 8'hB0);
    rd(PIF_OFS_FLAGS_ONE, 8'h20);
    @(posedge clk);
    req[5] <= 1'h0;
    req[4] <= 1'h1;
    wr(PIF_OFS_FLAGS_ONE, 8'h20);
    rd(PIF_OFS_FLAGS_ONE, 8'h10);
    @(posedge clk);
    req[4] <= 1'h0;
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      cc1_mode <= 2'(m);
      cc2_mode <= 2'(m);
      pulse(2);
      pulse(7);
      rd(PIF_OFS_FLAGS_ONE, m < 2 ? 8'h04 : 8'h00);
      rd(PIF_OFS_FLAGS_TWO, m < 2 ? 8'h01 : 8'h00);
      wr(PIF_OFS_FLAGS_ONE, 8'h00);
      wr(PIF_OFS_FLAGS_TWO, 8'h00);
    end
  endtask
  // stale summary events cleared before unmasking, as software should
  task automatic t_irq;
    wr(PIF_OFS_IRQ_STATUS, 8'h03);
    rd(PIF_OFS_IRQ_STATUS, 8'h00);
    pulse(12);
    rd(PIF_OFS_IRQ_STATUS, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wr(PIF_OFS_IRQ_MASK, 8'h03);
    rd(PIF_OFS_IRQ_MASK, 8'h03);
    chk({7'h00, irq}, 8'h01);
    wr(PIF_OFS_IRQ_STATUS, 8'h02);
    rd(PIF_OFS_IRQ_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic results;
    $display("mismatches %0d, comparisons %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_one();
    t_two();
    t_serial();
    t_modes();
    t_irq();
    results();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end
endmodule
